// *** verilog/vsac_pkg.sv ***
// Constants, field layouts and carrier types of the VME slave address and chain logic
package vsac_pkg;

    localparam logic [5:0] AM_A24_LO = 6'h38;
    localparam logic [5:0] AM_A24_HI = 6'h3F;
    localparam logic [5:0] AM_A32_LO = 6'h08;
    localparam logic [5:0] AM_A32_HI = 6'h0F;

    localparam logic [15:0] OFS_CHAIN_ADDR = 16'h1010;
    localparam logic [15:0] OFS_CHAIN_CTRL = 16'h1012;
    localparam logic [15:0] OFS_GEO = 16'h101E;
    localparam logic [15:0] OFS_BUF_HI = 16'h0FFF;

    localparam logic [7:0] CHAIN_ADDR_RST = 8'hAA;
    localparam logic [1:0] CHAIN_CTRL_RST = 2'h0;
    localparam logic [4:0] GEO_RST = 5'h00;
    localparam int CTRL_LAST_BIT = 0;
    localparam int CTRL_FIRST_BIT = 1;

    localparam int CLK_HZ = 20_000_000;
    localparam int CFG_TIME_MS = 1000;
    localparam int CFG_CYCLES = CFG_TIME_MS * (CLK_HZ / 1000);

    localparam logic [11:0] WIN_WIDTH_RST = 12'h014;
    localparam logic [15:0] WIN_OFFSET_RST = 16'hFFD8;
    localparam logic [11:0] EXTRA_SEARCH_RST = 12'h008;
    localparam logic [11:0] REJECT_MARGIN_RST = 12'h004;
    localparam logic [1:0] EDGE_LEADING = 2'h1;
    localparam logic [1:0] RES_100PS = 2'h2;
    localparam logic [1:0] DEAD_5NS = 2'h0;
    localparam logic [2:0] FIFO_256 = 3'h7;
    localparam logic [3:0] HITS_NO_LIMIT = 4'hF;

    typedef struct packed {
        logic trig_match;
        logic [11:0] win_width;
        logic [15:0] win_offset;
        logic [11:0] extra_search;
        logic [11:0] reject_margin;
        logic [1:0] edge_mode;
        logic [1:0] resolution;
        logic [1:0] dead_time;
        logic [2:0] fifo_size;
        logic [3:0] hit_limit;
        logic [127:0] chan_en;
    } vsac_tdc_cfg_t;

    localparam vsac_tdc_cfg_t TDC_CFG_RST = '{
        trig_match: 1'b0, win_width: WIN_WIDTH_RST, win_offset: WIN_OFFSET_RST,
        extra_search: EXTRA_SEARCH_RST, reject_margin: REJECT_MARGIN_RST,
        edge_mode: EDGE_LEADING, resolution: RES_100PS, dead_time: DEAD_5NS,
        fifo_size: FIFO_256, hit_limit: HITS_NO_LIMIT, chan_en: {128{1'b1}}};

    typedef struct packed {
        logic [31:0] addr;
        logic [5:0] am;
        logic as_b;
        logic ds_b;
        logic write_b;
        logic [15:0] data;
        logic iackin_b;
        logic berr_b;
        logic [15:0] sw;
    } vsac_pin_t;

    localparam vsac_pin_t PIN_RST = '{
        addr: 32'h0000_0000, am: 6'h00, as_b: 1'b1, ds_b: 1'b1, write_b: 1'b1,
        data: 16'h0000, iackin_b: 1'b1, berr_b: 1'b1, sw: 16'h0000};

endpackage : vsac_pkg

// *** verilog/vsac_top.sv ***
// VME slave address recognition, chain registers, token and power-up indicators
// Requirements
// RQ1 - Base addressing accepts A24 modifier codes 0x3F down to 0x38.
// RQ2 - Base addressing accepts A32 modifier codes 0x0F down to 0x08.
// RQ3 - Base address moves in 64 KB steps over the whole A24 or A32 space.
// RQ4 - Base address comes from four rotary hex switches, never from software.
// RQ5 - The shared chain address answers A32 modifier codes only.
// RQ6 - One write to the chain address updates registers on all boards; writes only.
// RQ7 - Chained reads are block transfers to the shared address, buffer only.
// RQ8 - Chain top address byte is a register, 0xAA after reset, equal chain-wide.
// RQ9 - Chain access: programmed byte on A31-24, zero on A23-16, offset below.
// RQ10 - Token comes in on IACKIN, leaves on IACKOUT; only its holder moves data.
// RQ11 - Flags: none inactive, last only last, first only first, both intermediate.
// RQ12 - Both chain flags clear after reset, so the board sits out.
// RQ13 - Software marks exactly one first and exactly one last board per chain.
// RQ14 - Software loads the slot number used in header and trailer top 5 bits.
// RQ15 - No empty slots between chained boards unless the crate bridges IACK.
// RQ16 - Separate chains in one crate need separate top address bytes.
// RQ17 - Power-up clears the output buffer and loads register defaults.
// RQ18 - Converters start unmatched, window 0x14, offset 0xFFD8, search 0x8, reject 0x4.
// RQ19 - Converters start leading edge, 100 ps, 5 ns dead time, FIFO 256, all on.
// RQ20 - Software reprograms the board after power-up or hardware reset.
// RQ21 - Full, error and data-ready lamps light while configuring, then go dark.
// RQ22 - Last board signals bus error after its final chained word.
// RQ23 - Unrecognised modifier or address leaves the bus alone.
`timescale 1ns/1ps
`default_nettype none

module vsac_top #(
    parameter int CFG_CYCLES = vsac_pkg::CFG_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    input wire logic [31:0] vme_addr,
    input wire logic [5:0] vme_am,
    input wire logic vme_as_b,
    input wire logic vme_ds_b,
    input wire logic vme_write_b,
    input wire logic [31:0] vme_data_i,
    output logic [31:0] vme_data_o,
    output logic vme_data_oe,
    output logic vme_dtack_oe,
    input wire logic vme_berr_i_b,
    output logic vme_berr_oe,
    input wire logic vme_iackin_b,
    output logic vme_iackout_b,
    input wire logic [15:0] base_sw,
    input wire logic [31:0] buf_word,
    input wire logic buf_empty,
    input wire logic buf_evt_end,
    input wire logic buf_full,
    input wire logic tdc_error,
    output logic buf_pop,
    output logic buf_clear,
    output logic tdc_load,
    output vsac_pkg::vsac_tdc_cfg_t tdc_cfg,
    output logic [4:0] geo_slot,
    output logic cfg_busy,
    output logic power_lamp,
    output logic full_lamp,
    output logic error_lamp,
    output logic data_ready_lamp
);

    localparam int CW = $clog2(CFG_CYCLES + 1);
    localparam logic [CW-1:0] CFG_LAST = CW'(CFG_CYCLES - 1);

    typedef enum logic [1:0] {ST_CFG, ST_IDLE, ST_ACK, ST_BERR} vsac_state_t;

    function automatic logic am_in(input logic [5:0] am, input logic [5:0] lo,
                                   input logic [5:0] hi);
        am_in = (am >= lo) && (am <= hi);
    endfunction : am_in

    vsac_pkg::vsac_pin_t pin_raw;
    vsac_pkg::vsac_pin_t p1_q;
    vsac_pkg::vsac_pin_t p2_q;
    vsac_state_t st_q;
    vsac_state_t st_d;
    logic [CW-1:0] cfg_cnt_q;
    logic [7:0] chain_addr_q;
    logic [1:0] chain_ctrl_q;
    logic [4:0] geo_q;
    logic passed_q;
    logic dtk_q;
    logic [31:0] rdata_q;
    logic drive_q;
    logic berr_seen_q;

    // Bus pins and switches go through the same two flops, so strobes and fields arrive in the same cycle
    assign pin_raw = '{
        addr: vme_addr, am: vme_am, as_b: vme_as_b, ds_b: vme_ds_b,
        write_b: vme_write_b, data: vme_data_i[15:0], iackin_b: vme_iackin_b,
        berr_b: vme_berr_i_b, sw: base_sw};

    wire logic strobe = !p2_q.as_b && !p2_q.ds_b;
    wire logic is_wr = !p2_q.write_b;
    wire logic [15:0] ofs = p2_q.addr[15:0];

    wire logic am_a24 = am_in(p2_q.am, vsac_pkg::AM_A24_LO, vsac_pkg::AM_A24_HI); // RQ1
    wire logic am_a32 = am_in(p2_q.am, vsac_pkg::AM_A32_LO, vsac_pkg::AM_A32_HI); // RQ2
    // Block codes have 11 or 00 in the low bits; the rest are data and program access
    wire logic am_blt = am_a32 && (p2_q.am[1:0] == 2'b11 || p2_q.am[1:0] == 2'b00); // RQ7

    // Switch pair 3..2 steers A31-24, pair 1..0 steers A23-16
    wire logic hit_a24 = am_a24 && (p2_q.addr[23:16] == p2_q.sw[7:0]); // RQ3 RQ4
    wire logic hit_a32 = am_a32 && (p2_q.addr[31:16] == p2_q.sw); // RQ3 RQ4
    wire logic hit_base = hit_a24 || hit_a32; // RQ23

    wire logic f_bit = chain_ctrl_q[vsac_pkg::CTRL_FIRST_BIT];
    wire logic l_bit = chain_ctrl_q[vsac_pkg::CTRL_LAST_BIT];
    wire logic active = f_bit || l_bit; // RQ11
    wire logic role_first = f_bit && !l_bit; // RQ11
    wire logic role_last = !f_bit && l_bit; // RQ11

    // Inactive boards never match the chain address, whatever the top byte holds
    wire logic hit_chain = active && am_a32 // RQ5
        && (p2_q.addr[31:24] == chain_addr_q) // RQ8 RQ9
        && (p2_q.addr[23:16] == 8'h00); // RQ9

    // The first board owns the token from the start, the others wait for IACKIN
    wire logic token = active && !passed_q && (role_first || !p2_q.iackin_b); // RQ10

    wire logic reg_ofs = (ofs == vsac_pkg::OFS_CHAIN_ADDR)
        || (ofs == vsac_pkg::OFS_CHAIN_CTRL) || (ofs == vsac_pkg::OFS_GEO);
    wire logic buf_ofs = (ofs <= vsac_pkg::OFS_BUF_HI);

    wire logic idle = (st_q == ST_IDLE);
    wire logic base_wr = idle && strobe && hit_base && is_wr && reg_ofs;
    wire logic base_rd = idle && strobe && hit_base && !is_wr && (reg_ofs || buf_ofs);
    wire logic mcst_wr = idle && strobe && hit_chain && is_wr && reg_ofs; // RQ6
    // Chained reads reach the buffer window only; register offsets stay silent
    wire logic cblt_rd = idle && strobe && hit_chain && !is_wr && am_blt // RQ7
        && token && buf_ofs; // RQ7 RQ10
    wire logic cblt_word = cblt_rd && !buf_empty;
    // Only the last board ends the chain; others just hand the token on
    wire logic cblt_end = cblt_rd && buf_empty && role_last; // RQ22
    wire logic cblt_skip = cblt_rd && buf_empty && !role_last; // RQ10
    wire logic reg_wr = base_wr || mcst_wr; // RQ6
    wire logic pop_base = base_rd && buf_ofs && !reg_ofs && !buf_empty;

    // Register read selection; the slot register is the fall-through case
    wire logic [15:0] reg_rd = (ofs == vsac_pkg::OFS_CHAIN_ADDR) ? {8'h00, chain_addr_q}
        : (ofs == vsac_pkg::OFS_CHAIN_CTRL) ? {14'h0000, chain_ctrl_q}
        : {11'h000, geo_q};
    wire logic [31:0] rdata_d = (cblt_word || !reg_ofs) ? buf_word : {16'h0000, reg_rd};

    // In a multicast write only the last board drives DTACK, avoiding a wired fight
    wire logic dtk_d = base_wr || base_rd || cblt_word || (mcst_wr && role_last);
    // Configuration ends on the last count, not one past it
    wire logic cfg_done = (cfg_cnt_q == CFG_LAST);

    // The bus is ignored until the configuration counter has run out
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_CFG: begin
                if (cfg_done) begin
                    st_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cblt_end) begin
                    st_d = ST_BERR;
                end else if (dtk_d || mcst_wr) begin
                    st_d = ST_ACK;
                end
            end
            ST_ACK, ST_BERR: begin
                if (p2_q.ds_b) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Switches share these flops; they may be turned while powered
            p1_q <= vsac_pkg::PIN_RST;
            p2_q <= vsac_pkg::PIN_RST;
        end else if (en) begin
            p1_q <= pin_raw;
            p2_q <= p1_q;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // The counter stops at its last value so the load pulse fires once
            st_q <= ST_CFG;
            cfg_cnt_q <= '0;
        end else if (en) begin
            st_q <= st_d;
            if (!cfg_done) begin
                cfg_cnt_q <= cfg_cnt_q + CW'(1);
            end
        end
    end

    // Registers return to defaults at reset; software must load them again
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chain_addr_q <= vsac_pkg::CHAIN_ADDR_RST; // RQ8 RQ17
            chain_ctrl_q <= vsac_pkg::CHAIN_CTRL_RST; // RQ12 RQ17
            geo_q <= vsac_pkg::GEO_RST; // RQ17
        end else if (en && reg_wr) begin
            if (ofs == vsac_pkg::OFS_CHAIN_ADDR) begin
                chain_addr_q <= p2_q.data[7:0]; // RQ8
            end
            if (ofs == vsac_pkg::OFS_CHAIN_CTRL) begin
                chain_ctrl_q <= p2_q.data[1:0]; // RQ11
            end
            if (ofs == vsac_pkg::OFS_GEO) begin
                geo_q <= p2_q.data[4:0]; // RQ14
            end
        end
    end

    // Token state clears when any board raises bus error, ending the chained read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            passed_q <= 1'b0;
            berr_seen_q <= 1'b0;
        end else if (en) begin
            berr_seen_q <= !p2_q.berr_b;
            if (!p2_q.berr_b || reg_wr) begin
                passed_q <= 1'b0;
            end else if (cblt_skip || (cblt_word && buf_evt_end)) begin
                passed_q <= 1'b1; // RQ10
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Answer and data stay latched until the master lifts its data strobe
            dtk_q <= 1'b0;
            drive_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (en) begin
            if (idle) begin
                dtk_q <= dtk_d;
                drive_q <= base_rd || cblt_word;
                rdata_q <= rdata_d;
            end else if (p2_q.ds_b) begin
                dtk_q <= 1'b0;
                drive_q <= 1'b0;
            end
        end
    end

    // Pass-through keeps the IACK chain alive for boards outside any chain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vme_iackout_b <= 1'b1;
        end else if (en) begin
            vme_iackout_b <= active ? !passed_q : p2_q.iackin_b; // RQ10
        end
    end

    // Full, error and data-ready lamps stay lit for the whole configuration time
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            full_lamp <= 1'b1;
            error_lamp <= 1'b1;
            data_ready_lamp <= 1'b1;
            power_lamp <= 1'b0;
        end else if (en) begin
            full_lamp <= (st_q == ST_CFG) || buf_full; // RQ21
            error_lamp <= (st_q == ST_CFG) || tdc_error; // RQ21
            data_ready_lamp <= (st_q == ST_CFG) || !buf_empty; // RQ21
            power_lamp <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Pop is registered alongside the acknowledge and rises in the same cycle as DTACK
            buf_pop <= 1'b0;
            tdc_load <= 1'b0;
        end else if (en) begin
            buf_pop <= cblt_word || pop_base;
            tdc_load <= (st_q == ST_CFG) && cfg_done; // RQ18 RQ19
        end
    end

    // Converter defaults are fixed; software must reprogram them after every reset
    assign tdc_cfg = vsac_pkg::TDC_CFG_RST; // RQ18 RQ19
    assign buf_clear = (st_q == ST_CFG); // RQ17
    assign cfg_busy = (st_q == ST_CFG);
    assign geo_slot = geo_q;
    assign vme_data_o = rdata_q;
    // Data is released as soon as the strobe lifts, before the acknowledge drops
    assign vme_data_oe = drive_q && (st_q == ST_ACK) && !p2_q.ds_b;
    assign vme_dtack_oe = dtk_q && (st_q == ST_ACK); // RQ23
    // Held while the master keeps its strobe low, and after that until bus error shows on the line
    assign vme_berr_oe = (st_q == ST_BERR) && (!berr_seen_q || !p2_q.ds_b); // RQ22

endmodule : vsac_top

`default_nettype wire

// *** test/vsac_props.sv ***
// Port assertions of the VME slave address and chain logic
`timescale 1ns/1ps
`default_nettype none
module vsac_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [31:0] vme_addr,
    input wire logic [5:0] vme_am,
    input wire logic vme_as_b,
    input wire logic vme_ds_b,
    input wire logic vme_write_b,
    input wire logic vme_data_oe,
    input wire logic vme_dtack_oe,
    input wire logic vme_berr_oe,
    input wire logic [15:0] base_sw,
    input wire logic buf_empty,
    input wire logic buf_full,
    input wire logic buf_clear,
    input wire logic tdc_load,
    input wire vsac_pkg::vsac_tdc_cfg_t tdc_cfg,
    input wire logic cfg_busy,
    input wire logic power_lamp,
    input wire logic full_lamp,
    input wire logic error_lamp,
    input wire logic data_ready_lamp
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic am_a24 = vme_am[5:3] == 3'h7;
    wire logic am_a32 = vme_am[5:3] == 3'h1;
    wire logic am_blk = vme_am[1:0] == 2'h3 || vme_am[1:0] == 2'h0;
    wire logic cblt = vme_write_b && am_a32 && am_blk && vme_addr[23:16] == 8'h00;
    // Load pulse carries the power-up converter set and lasts one cycle
    sequence s_load_pulse;
        tdc_load && tdc_cfg == vsac_pkg::TDC_CFG_RST ##1 !tdc_load;
    endsequence
    property p_dtack_cause; $rose(vme_dtack_oe) |-> $past(!vme_ds_b && !vme_as_b, 2); endproperty
    property p_am_known; $rose(vme_dtack_oe) |-> $past(am_a24 || am_a32, 2); endproperty
    property p_base_a24;
        $rose(vme_dtack_oe) && $past(am_a24, 2) |-> $past(vme_addr[23:16], 2) == base_sw[7:0];
    endproperty
    property p_berr_end; $rose(vme_berr_oe) |-> $past(cblt, 2) && buf_empty; endproperty
    property p_read_data; $rose(vme_data_oe) |-> $past(vme_write_b, 2); endproperty
    property p_lamps_cfg; cfg_busy |-> full_lamp && error_lamp && data_ready_lamp; endproperty
    property p_full_follow; $past(!cfg_busy) |-> full_lamp == $past(buf_full); endproperty
    property p_clear_cfg; cfg_busy |-> buf_clear; endproperty
    property p_load_defaults; tdc_load |-> s_load_pulse; endproperty
    property p_power; $past(rst_b) |-> power_lamp; endproperty
    a_dtack_cause: assert property (p_dtack_cause) else $error("ack without strobes");
    a_am_known: assert property (p_am_known) else $error("ack on foreign modifier");
    a_base_a24: assert property (p_base_a24) else $error("ack off base");
    a_berr_end: assert property (p_berr_end) else $error("bad bus error");
    a_read_data: assert property (p_read_data) else $error("data driven on write");
    a_lamps_cfg: assert property (p_lamps_cfg) else $error("lamp dark in config");
    a_full_follow: assert property (p_full_follow) else $error("full lamp stale");
    a_clear_cfg: assert property (p_clear_cfg) else $error("buffer kept in config");
    a_load_defaults: assert property (p_load_defaults) else $error("bad load");
    a_power: assert property (p_power) else $error("power lamp dark");
endmodule : vsac_props
bind vsac_top vsac_props i_props (.clk(clk), .rst_b(rst_b), .vme_addr(vme_addr),
    .vme_am(vme_am), .vme_as_b(vme_as_b), .vme_ds_b(vme_ds_b), .vme_write_b(vme_write_b),
    .vme_data_oe(vme_data_oe), .vme_dtack_oe(vme_dtack_oe), .vme_berr_oe(vme_berr_oe),
    .base_sw(base_sw), .buf_empty(buf_empty), .buf_full(buf_full), .buf_clear(buf_clear),
    .tdc_load(tdc_load), .tdc_cfg(tdc_cfg), .cfg_busy(cfg_busy), .power_lamp(power_lamp),
    .full_lamp(full_lamp), .error_lamp(error_lamp), .data_ready_lamp(data_ready_lamp));
`default_nettype wire

// *** test/vsac_master.sv ***
// Bus master model running single VME cycles against the board
`timescale 1ns/1ps
`default_nettype none
module vsac_master (
    input wire logic clk,
    input wire logic dtack_oe,
    input wire logic berr_oe,
    input wire logic [31:0] data_o,
    output logic [31:0] addr,
    output logic [5:0] am,
    output logic as_b,
    output logic ds_b,
    output logic write_b,
    output logic [31:0] data
);
    initial begin
        addr = 32'h0000_0000;
        am = 6'h00;
        as_b = 1'b1;
        ds_b = 1'b1;
        write_b = 1'b1;
        data = 32'h0000_0000;
    end
    // Response: 0 none, 1 acknowledge, 2 bus error; silence is cut after 16 cycles
    task automatic cyc(input logic [31:0] a, input logic [5:0] m, input logic wr,
        input logic [15:0] d, output logic [1:0] resp, output logic [31:0] rd);
        int n;
        resp = 2'h0;
        rd = 32'h0000_0000;
        @(posedge clk);
        #1;
        addr = a;
        am = m;
        write_b = !wr;
        data = wr ? {16'h0000, d} : ~data;
        as_b = 1'b0;
        ds_b = 1'b0;
        for (n = 0; n < 16 && resp == 2'h0; n++) begin
            @(posedge clk);
            if (dtack_oe === 1'b1) begin
                resp = 2'h1;
                rd = data_o;
            end else if (berr_oe === 1'b1) begin
                resp = 2'h2;
            end
        end
        #1;
        as_b = 1'b1;
        ds_b = 1'b1;
        // Address and data lines never keep the last value
        addr = ~addr;
        data = ~data;
        for (n = 0; n < 16 && (dtack_oe | berr_oe) !== 1'b0; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        // Callers change their inputs next, so keep them off the sampling edge
        #1;
    endtask : cyc
endmodule : vsac_master
`default_nettype wire

// *** test/vsac_top_tb.sv ***
// Self-checking testbench of the VME slave address and chain logic
`timescale 1ns/1ps
`default_nettype none
module vsac_top_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic en = 1'b1;
    logic [15:0] base_sw = 16'hCC11;
    logic [31:0] buf_word = 32'h1234_5678;
    logic buf_empty = 1'b1;
    logic buf_evt_end = 1'b1;
    logic buf_full = 1'b0;
    logic tdc_error = 1'b0;
    logic iackin_b = 1'b1;
    logic [1:0] resp;
    logic [31:0] rd;
    int error_cnt = 0;
    int checks_done = 0;
    int pops = 0;
    wire logic [31:0] vme_addr, vme_data_i, vme_data_o;
    wire logic [5:0] vme_am;
    wire logic vme_as_b, vme_ds_b, vme_write_b, vme_data_oe, vme_dtack_oe, vme_berr_oe;
    wire logic vme_iackout_b, buf_pop, buf_clear, tdc_load, cfg_busy;
    wire logic power_lamp, full_lamp, error_lamp, data_ready_lamp;
    wire logic [4:0] geo_slot;
    wire vsac_pkg::vsac_tdc_cfg_t tdc_cfg;
    always #25 clk = ~clk;
    always @(posedge clk) if (buf_pop === 1'b1) pops++;
    vsac_master i_mst (.clk(clk), .dtack_oe(vme_dtack_oe), .berr_oe(vme_berr_oe),
        .data_o(vme_data_o), .addr(vme_addr), .am(vme_am), .as_b(vme_as_b), .ds_b(vme_ds_b),
        .write_b(vme_write_b), .data(vme_data_i));
    vsac_top #(.CFG_CYCLES(8)) i_dut (.clk(clk), .rst_b(rst_b), .en(en), .vme_addr(vme_addr),
        .vme_am(vme_am), .vme_as_b(vme_as_b), .vme_ds_b(vme_ds_b), .vme_write_b(vme_write_b),
        .vme_data_i(vme_data_i), .vme_data_o(vme_data_o), .vme_data_oe(vme_data_oe),
        .vme_dtack_oe(vme_dtack_oe), .vme_berr_i_b(!vme_berr_oe), .vme_berr_oe(vme_berr_oe),
        .vme_iackin_b(iackin_b), .vme_iackout_b(vme_iackout_b), .base_sw(base_sw),
        .buf_word(buf_word), .buf_empty(buf_empty), .buf_evt_end(buf_evt_end),
        .buf_full(buf_full), .tdc_error(tdc_error), .buf_pop(buf_pop), .buf_clear(buf_clear),
        .tdc_load(tdc_load), .tdc_cfg(tdc_cfg), .geo_slot(geo_slot), .cfg_busy(cfg_busy),
        .power_lamp(power_lamp), .full_lamp(full_lamp), .error_lamp(error_lamp),
        .data_ready_lamp(data_ready_lamp));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic [31:0] a, input logic [5:0] m, input logic rnw,
        input logic [15:0] d);
        // Scenarios pass read-not-write; the master model takes a write flag
        i_mst.cyc(a, m, !rnw, d, resp, rd);
    endtask : acc
    task automatic t_power();
        @(posedge clk);
        #1;
        chk({power_lamp, cfg_busy, buf_clear}, 3'h7);
        chk({full_lamp, error_lamp, data_ready_lamp}, 3'h7);
        for (int n = 0; n < 40 && cfg_busy !== 1'b0; n++) @(posedge clk);
        #1;
        chk(tdc_cfg === vsac_pkg::TDC_CFG_RST, 1'b1);
        buf_full = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({buf_clear, full_lamp, error_lamp, data_ready_lamp}, 4'h4);
        buf_full = 1'b0;
        tdc_error = 1'b1;
        buf_empty = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({full_lamp, error_lamp, data_ready_lamp}, 3'h3);
        tdc_error = 1'b0;
        buf_empty = 1'b1;
    endtask : t_power
    task automatic t_regs();
        acc(32'hCC11_1010, 6'h09, 1'b1, 16'h0000);
        chk({resp, rd[7:0]}, {2'h1, 8'hAA});
        acc(32'h0011_1012, 6'h39, 1'b1, 16'h0000);
        chk({resp, rd[1:0]}, {2'h1, 2'h0});
        acc(32'hCC11_1000, 6'h0D, 1'b1, 16'h0000);
        chk(resp, 2'h0);
        acc(32'hCD11_1010, 6'h0D, 1'b1, 16'h0000);
        chk(resp, 2'h0);
        acc(32'hCC11_101E, 6'h0E, 1'b0, 16'h0015);
        chk({resp, 3'h0, geo_slot}, {2'h1, 8'h15});
    endtask : t_regs
    task automatic t_am();
        for (int m = 0; m < 64; m++) begin
            acc(m[5] ? 32'h0011_1010 : 32'hCC11_1010, m[5:0], 1'b1, 16'h0000);
            chk(resp, {1'b0, m[5:3] == 3'h7 || m[5:3] == 3'h1});
        end
    endtask : t_am
    task automatic t_chain();
        acc(32'hCC11_1010, 6'h0D, 1'b0, 16'h005A);
        acc(32'hCC11_1012, 6'h0D, 1'b0, 16'h0001);
        acc(32'h5A00_1012, 6'h39, 1'b0, 16'h0001);
        chk(resp, 2'h0);
        acc(32'h5A01_1012, 6'h09, 1'b0, 16'h0001);
        chk(resp, 2'h0);
        acc(32'h5A00_101E, 6'h09, 1'b0, 16'h0007);
        chk({resp, 3'h0, geo_slot}, {2'h1, 8'h07});
        buf_empty = 1'b0;
        acc(32'h5A00_0000, 6'h0B, 1'b1, 16'h0000);
        chk(resp, 2'h0);
        iackin_b = 1'b0;
        acc(32'h5A00_1010, 6'h0B, 1'b1, 16'h0000);
        chk(resp, 2'h0);
        acc(32'h5A00_0000, 6'h0F, 1'b1, 16'h0000);
        chk({30'h0, resp}, 32'h1);
        chk(rd, 32'h1234_5678);
        acc(32'h5A00_1012, 6'h09, 1'b0, 16'h0001);
        buf_empty = 1'b1;
        acc(32'h5A00_0000, 6'h08, 1'b1, 16'h0000);
        chk(resp, 2'h2);
        acc(32'hCC11_1012, 6'h0D, 1'b0, 16'h0002);
        iackin_b = 1'b1;
        buf_empty = 1'b0;
        acc(32'h5A00_0000, 6'h09, 1'b1, 16'h0000);
        chk({resp, vme_iackout_b}, 3'h1);
        acc(32'h5A00_0000, 6'h0C, 1'b1, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        chk({resp, vme_iackout_b, pops[3:0]}, {2'h1, 1'b0, 4'h2});
        acc(32'hCC11_1012, 6'h0D, 1'b0, 16'h0000);
        iackin_b = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(vme_iackout_b, 1'b0);
    endtask : t_chain
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_b = 1'b1;
        t_power();
        t_regs();
        t_am();
        t_chain();
        conclude();
    end
    // The whole sequence needs about 1400 cycles
    initial begin
        #(50 * 20000);
        error_cnt++;
        conclude();
    end
endmodule : vsac_top_tb
`default_nettype wire
